// >>> core/dbp_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Brake chopper on while bus voltage is at or above programmed level.
// - Injection current is the percent level of motor rated current.
// - Run command injects DC for start time first; zero skips.
// - Stop braking only when stop method is ramp, for stop time.
// - Stop braking time zero disables braking at stop.
// - Ramp stop brakes once output frequency reaches stop brake frequency.
// - Stop frequency below start-up frequency brakes at minimum frequency.
// - Tracking voltage rises per tick by the gain percentage.
// - Loss mode 0 stops, 1 tracks last speed, 2 tracks minimum.
// - Tracking accelerates to command only after synchronisation is reported.
// - With encoder feedback and nonzero mode, track from encoder speed.
// - Outage longer than allowed time keeps output off after return.
// - Restart mode applies only to undervoltage; overload ignores it.
// - After a loss, output blocks for base block time before resuming.
module dbp_core #(
  parameter int TICK_CYCLES = dbp_pkg::TICK_CYCLES,
  parameter bit HIGH_VOLT = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [12:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins from the drive.
  input wire logic run_cmd,
  input wire logic undervoltage_indication,
  input wire logic overload_error,
  // Measurements from same-clock logic.
  input wire logic [15:0] dc_bus_volt,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] enc_speed,
  input wire logic track_synced,
  // Power stage outputs.
  output dbp_pkg::dbp_drive_t drive,
  output logic irq
);
  typedef struct packed {
    logic [15:0] brk_lvl;
    logic [15:0] inj_cur;
    logic [15:0] start_t;
    logic [15:0] stop_t;
    logic [15:0] stop_f;
    logic [15:0] gain;
    logic [15:0] mode;
    logic [15:0] allow_t;
    logic [15:0] block_t;
    logic [15:0] stop_sel;
    logic [15:0] startup_f;
    logic [15:0] min_f;
    logic [15:0] rated;
    logic enc_en;
    logic [3:0] ist;
    logic [3:0] ien;
    logic [1:0] run_s;
    logic [1:0] uv_s;
    logic [1:0] ol_s;
    dbp_pkg::dbp_state_t st;
    logic [21:0] div;
    logic tick;
    logic [15:0] cnt;
    logic [15:0] last_f;
    logic irq;
    logic wait_r;
    logic [31:0] rdata;
    dbp_pkg::dbp_drive_t drv;
  } dbp_regs_t;

  dbp_regs_t r_reg;
  dbp_regs_t r_next;
  logic [15:0] thr;
  logic [31:0] prod;

  function automatic logic hit(input logic [12:0] a, input logic [10:0] i);
    hit = (a[12:2] == i);
  endfunction

  // Braking frequency threshold falls back to minimum when set too low.
  assign thr = (r_reg.stop_f < r_reg.startup_f) ? r_reg.min_f
                                                 : r_reg.stop_f;
  // Percent is clamped so injection never exceeds the rated current.
  assign prod = r_reg.rated * ((r_reg.inj_cur > dbp_pkg::PCT_FULL) ?
                dbp_pkg::PCT_FULL : r_reg.inj_cur);

  // Next-state logic for registers, sequencer and bus.
  always_comb begin
    logic req;
    logic [3:0] ev;
    logic [16:0] vsum;
    req = 1'b0;
    ev = 4'h0;
    vsum = 17'h00000;
    r_next = r_reg;
    r_next.run_s = {r_reg.run_s[0], run_cmd};
    r_next.uv_s = {r_reg.uv_s[0], undervoltage_indication};
    r_next.ol_s = {r_reg.ol_s[0], overload_error};
    // Tick divider for the 0.1 s timebase.
    r_next.tick = 1'b0;
    if (r_reg.div >= 22'(TICK_CYCLES - 1)) begin
      r_next.div = 22'h000000;
      r_next.tick = 1'b1;
    end else begin
      r_next.div = r_reg.div + 22'h000001;
    end
    // Sequencer.
    unique case (r_reg.st)
      dbp_pkg::ST_IDLE: begin
        if (r_reg.run_s[1]) begin
          if (r_reg.start_t != dbp_pkg::RST_ZERO) begin
            r_next.st = dbp_pkg::ST_START_BRK;
          end else begin
            r_next.st = dbp_pkg::ST_RUN;
          end
        end
      end
      dbp_pkg::ST_START_BRK: begin
        if (r_reg.cnt >= r_reg.start_t) begin
          r_next.st = dbp_pkg::ST_RUN;
        end
      end
      dbp_pkg::ST_RUN, dbp_pkg::ST_DECEL, dbp_pkg::ST_TRACK: begin
        if (r_reg.st == dbp_pkg::ST_RUN) begin
          r_next.last_f = out_freq;
        end
        if (r_reg.ol_s[1]) begin
          r_next.st = dbp_pkg::ST_HALT;
          ev[dbp_pkg::IRQ_TRIP] = 1'b1;
        end else if (r_reg.uv_s[1]) begin
          r_next.st = dbp_pkg::ST_OUTAGE;
          ev[dbp_pkg::IRQ_LOSS] = 1'b1;
        end else if (r_reg.st == dbp_pkg::ST_TRACK) begin
          if (track_synced) begin
            r_next.st = dbp_pkg::ST_RUN;
          end
        end else if (r_reg.run_s[1]) begin
          r_next.st = dbp_pkg::ST_RUN;
        end else if (r_reg.st == dbp_pkg::ST_RUN) begin
          r_next.st = dbp_pkg::ST_DECEL;
        end else if (out_freq <= thr) begin
          if (r_reg.stop_sel == dbp_pkg::RST_ZERO &&
              r_reg.stop_t != dbp_pkg::RST_ZERO) begin
            r_next.st = dbp_pkg::ST_STOP_BRK;
          end else begin
            r_next.st = dbp_pkg::ST_IDLE;
          end
        end
      end
      dbp_pkg::ST_STOP_BRK: begin
        if (r_reg.cnt >= r_reg.stop_t) begin
          r_next.st = dbp_pkg::ST_IDLE;
        end
      end
      dbp_pkg::ST_OUTAGE: begin
        if (r_reg.ol_s[1]) begin
          r_next.st = dbp_pkg::ST_HALT;
          ev[dbp_pkg::IRQ_TRIP] = 1'b1;
        end else if (!r_reg.uv_s[1]) begin
          if (r_reg.cnt > r_reg.allow_t ||
              r_reg.mode == dbp_pkg::RST_ZERO) begin
            r_next.st = dbp_pkg::ST_HALT;
            ev[dbp_pkg::IRQ_TRIP] = 1'b1;
          end else begin
            r_next.st = dbp_pkg::ST_BLOCK;
          end
        end
      end
      dbp_pkg::ST_BLOCK: begin
        if (r_reg.uv_s[1]) begin
          r_next.st = dbp_pkg::ST_OUTAGE;
        end else if (r_reg.cnt >= r_reg.block_t) begin
          r_next.st = dbp_pkg::ST_TRACK;
          ev[dbp_pkg::IRQ_TRACK] = 1'b1;
          r_next.drv.trk_volt = dbp_pkg::RST_ZERO;
          if (r_reg.enc_en) begin
            r_next.drv.trk_f = enc_speed;
          end else if (r_reg.mode == 16'h0001) begin
            r_next.drv.trk_f = r_reg.last_f;
          end else begin
            r_next.drv.trk_f = r_reg.min_f;
          end
        end
      end
      dbp_pkg::ST_HALT: begin
        // After a trip, output stays off until run is withdrawn.
        if (!r_reg.run_s[1]) begin
          r_next.st = dbp_pkg::ST_IDLE;
        end
      end
      default: r_next.st = dbp_pkg::ST_IDLE;
    endcase
    // Duration counter restarts on every state change.
    if (r_next.st != r_reg.st) begin
      r_next.cnt = dbp_pkg::RST_ZERO;
    end else if (r_reg.tick && r_reg.cnt != 16'hFFFF) begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
    // Tracking voltage rises by the gain each tick, saturating.
    if (r_reg.st == dbp_pkg::ST_TRACK && r_reg.tick) begin
      vsum = {1'b0, r_reg.drv.trk_volt} + {1'b0, r_reg.gain};
      r_next.drv.trk_volt = vsum[16] ? 16'hFFFF : vsum[15:0];
    end
    // Outputs; frequency output and injection are exclusive by state.
    r_next.drv.chop = (dc_bus_volt >= r_reg.brk_lvl);
    if (r_next.drv.chop && !r_reg.drv.chop) begin
      ev[dbp_pkg::IRQ_CHOP] = 1'b1;
    end
    r_next.drv.inj_en = (r_next.st == dbp_pkg::ST_START_BRK ||
                         r_next.st == dbp_pkg::ST_STOP_BRK);
    r_next.drv.out_en = (r_next.st == dbp_pkg::ST_RUN ||
                         r_next.st == dbp_pkg::ST_DECEL ||
                         r_next.st == dbp_pkg::ST_TRACK);
    r_next.drv.trk = (r_next.st == dbp_pkg::ST_TRACK);
    r_next.drv.inj_amp = 16'(prod / 32'd100);
    // Bus: one wait cycle, then the access completes.
    req = (avs_read || avs_write) && r_reg.wait_r;
    r_next.wait_r = !req;
    if (req) begin
      r_next.rdata = 32'h00000000;
      if (hit(avs_address, dbp_pkg::IDX_BRK_LVL))
        r_next.rdata[15:0] = r_reg.brk_lvl;
      if (hit(avs_address, dbp_pkg::IDX_INJ_CUR))
        r_next.rdata[15:0] = r_reg.inj_cur;
      if (hit(avs_address, dbp_pkg::IDX_START_T))
        r_next.rdata[15:0] = r_reg.start_t;
      if (hit(avs_address, dbp_pkg::IDX_STOP_T))
        r_next.rdata[15:0] = r_reg.stop_t;
      if (hit(avs_address, dbp_pkg::IDX_STOP_F))
        r_next.rdata[15:0] = r_reg.stop_f;
      if (hit(avs_address, dbp_pkg::IDX_GAIN))
        r_next.rdata[15:0] = r_reg.gain;
      if (hit(avs_address, dbp_pkg::IDX_MODE))
        r_next.rdata[15:0] = r_reg.mode;
      if (hit(avs_address, dbp_pkg::IDX_ALLOW_T))
        r_next.rdata[15:0] = r_reg.allow_t;
      if (hit(avs_address, dbp_pkg::IDX_BLOCK_T))
        r_next.rdata[15:0] = r_reg.block_t;
      if (hit(avs_address, dbp_pkg::IDX_STOP_SEL))
        r_next.rdata[15:0] = r_reg.stop_sel;
      if (hit(avs_address, dbp_pkg::IDX_STARTUP_F))
        r_next.rdata[15:0] = r_reg.startup_f;
      if (hit(avs_address, dbp_pkg::IDX_MIN_F))
        r_next.rdata[15:0] = r_reg.min_f;
      if (hit(avs_address, dbp_pkg::IDX_RATED))
        r_next.rdata[15:0] = r_reg.rated;
      if (hit(avs_address, dbp_pkg::IDX_CTRL))
        r_next.rdata[0] = r_reg.enc_en;
      if (hit(avs_address, dbp_pkg::IDX_STATUS))
        r_next.rdata[7:0] = {r_reg.drv.chop, r_reg.drv.out_en,
                             r_reg.drv.inj_en, r_reg.drv.trk, r_reg.st};
      if (hit(avs_address, dbp_pkg::IDX_IRQ_STAT))
        r_next.rdata[3:0] = r_reg.ist;
      if (hit(avs_address, dbp_pkg::IDX_IRQ_EN))
        r_next.rdata[3:0] = r_reg.ien;
    end
    // Writes land on the cycle that waitrequest is low.
    if (avs_write && !r_reg.wait_r) begin
      if (hit(avs_address, dbp_pkg::IDX_BRK_LVL))
        r_next.brk_lvl = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_INJ_CUR))
        r_next.inj_cur = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_START_T))
        r_next.start_t = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_STOP_T))
        r_next.stop_t = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_STOP_F))
        r_next.stop_f = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_GAIN))
        r_next.gain = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_MODE))
        r_next.mode = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_ALLOW_T))
        r_next.allow_t = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_BLOCK_T))
        r_next.block_t = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_STOP_SEL))
        r_next.stop_sel = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_STARTUP_F))
        r_next.startup_f = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_MIN_F))
        r_next.min_f = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_RATED))
        r_next.rated = avs_writedata[15:0];
      if (hit(avs_address, dbp_pkg::IDX_CTRL))
        r_next.enc_en = avs_writedata[0];
      if (hit(avs_address, dbp_pkg::IDX_IRQ_CLR))
        r_next.ist = r_reg.ist & ~avs_writedata[3:0];
      if (hit(avs_address, dbp_pkg::IDX_IRQ_EN))
        r_next.ien = avs_writedata[3:0];
    end
    // A new event beats a clear in the same cycle.
    r_next.ist = r_next.ist | ev;
    r_next.irq = |(r_next.ist & r_next.ien);
  end

  // Single state register; synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.brk_lvl <= HIGH_VOLT ? dbp_pkg::RST_BRK_HV : dbp_pkg::RST_BRK_LV;
      r_reg.gain <= dbp_pkg::RST_GAIN;
      r_reg.allow_t <= dbp_pkg::RST_ALLOW_T;
      r_reg.block_t <= dbp_pkg::RST_BLOCK_T;
      r_reg.wait_r <= 1'b1;
      r_reg.st <= dbp_pkg::ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata = r_reg.rdata;
  assign avs_waitrequest = r_reg.wait_r;
  assign drive = r_reg.drv;
  assign irq = r_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_loss_back;
    r_reg.st == dbp_pkg::ST_OUTAGE && !r_reg.uv_s[1] && !r_reg.ol_s[1] &&
    r_reg.cnt <= r_reg.allow_t && r_reg.mode != dbp_pkg::RST_ZERO;
  endsequence
  sequence s_blocked;
    r_reg.st == dbp_pkg::ST_BLOCK && !drive.out_en ##1 !drive.inj_en;
  endsequence

  a_chop_level: assert property (dc_bus_volt >= r_reg.brk_lvl |=> drive.chop)
    else $error("Chopper not on at level.");
  a_inj_zero: assert property (r_reg.inj_cur == 16'h0000 |=>
    drive.inj_amp == 16'h0000) else $error("Zero level injects.");
  a_start_brk: assert property (r_reg.st == dbp_pkg::ST_IDLE &&
    r_reg.run_s[1] && r_reg.start_t != 16'h0000 |=> drive.inj_en &&
    !drive.out_en) else $error("Start braking missing.");
  a_stop_sel: assert property (r_reg.st == dbp_pkg::ST_STOP_BRK |->
    r_reg.stop_sel == 16'h0000 && r_reg.stop_t != 16'h0000)
    else $error("Stop braking not allowed.");
  a_stop_freq: assert property (r_reg.st == dbp_pkg::ST_DECEL &&
    out_freq > thr |=> r_reg.st != dbp_pkg::ST_STOP_BRK)
    else $error("Stop braking too early.");
  a_mode_stop: assert property (r_reg.st == dbp_pkg::ST_OUTAGE &&
    !r_reg.uv_s[1] && r_reg.mode == 16'h0000 |=>
    r_reg.st == dbp_pkg::ST_HALT) else $error("Mode 0 restarted.");
  a_track_sync: assert property (r_reg.st == dbp_pkg::ST_TRACK &&
    !track_synced && !r_reg.ol_s[1] && !r_reg.uv_s[1] |=>
    r_reg.st == dbp_pkg::ST_TRACK) else $error("Left tracking early.");
  a_loss_resume: assert property (s_loss_back |=> s_blocked)
    else $error("No base block after loss.");
  a_ol_ignore: assert property (r_reg.st == dbp_pkg::ST_OUTAGE &&
    r_reg.ol_s[1] |=> r_reg.st == dbp_pkg::ST_HALT ##1 !drive.out_en)
    else $error("Overload loss restarted.");
  a_exclusive: assert property (!(drive.out_en && drive.inj_en))
    else $error("Output and injection together.");
  a_tick_pulse: assert property (r_reg.tick |=> !r_reg.tick)
    else $error("Tick longer than one cycle.");
  a_enc_track: assert property (r_reg.enc_en &&
    r_reg.st == dbp_pkg::ST_BLOCK && r_next.st == dbp_pkg::ST_TRACK |=>
    drive.trk_f == $past(enc_speed)) else $error("Encoder speed unused.");
endmodule // dbp_core

// >>> core/dbp_pkg.sv
package dbp_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [10:0] IDX_BRK_LVL = 11'h000;
  localparam logic [10:0] IDX_INJ_CUR = 11'h701;
  localparam logic [10:0] IDX_START_T = 11'h702;
  localparam logic [10:0] IDX_STOP_T = 11'h703;
  localparam logic [10:0] IDX_STOP_F = 11'h704;
  localparam logic [10:0] IDX_GAIN = 11'h705;
  localparam logic [10:0] IDX_MODE = 11'h706;
  localparam logic [10:0] IDX_ALLOW_T = 11'h707;
  localparam logic [10:0] IDX_BLOCK_T = 11'h708;
  localparam logic [10:0] IDX_STOP_SEL = 11'h710;
  localparam logic [10:0] IDX_STARTUP_F = 11'h711;
  localparam logic [10:0] IDX_MIN_F = 11'h712;
  localparam logic [10:0] IDX_RATED = 11'h713;
  localparam logic [10:0] IDX_CTRL = 11'h714;
  localparam logic [10:0] IDX_STATUS = 11'h715;
  localparam logic [10:0] IDX_IRQ_STAT = 11'h716;
  localparam logic [10:0] IDX_IRQ_CLR = 11'h717;
  localparam logic [10:0] IDX_IRQ_EN = 11'h718;
  // Reset values; voltages in 0.1 V, times in 0.1 s, gain in percent.
  localparam logic [15:0] RST_BRK_LV = 16'h0E74;
  localparam logic [15:0] RST_BRK_HV = 16'h1CE8;
  localparam logic [15:0] RST_GAIN = 16'h0064;
  localparam logic [15:0] RST_ALLOW_T = 16'h0014;
  localparam logic [15:0] RST_BLOCK_T = 16'h0005;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  // Interrupt bit positions.
  localparam int IRQ_CHOP = 0;
  localparam int IRQ_LOSS = 1;
  localparam int IRQ_TRACK = 2;
  localparam int IRQ_TRIP = 3;
  // Timebase.
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint TICK_NS = 100000000;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_START_BRK = 4'h1, ST_RUN = 4'h2,
    ST_DECEL = 4'h3, ST_STOP_BRK = 4'h4, ST_OUTAGE = 4'h5,
    ST_BLOCK = 4'h6, ST_TRACK = 4'h7, ST_HALT = 4'h8
  } dbp_state_t;
  // Drive outputs toward the power stage.
  typedef struct packed {
    logic chop;
    logic out_en;
    logic inj_en;
    logic trk;
    logic [15:0] inj_amp;
    logic [15:0] trk_f;
    logic [15:0] trk_volt;
  } dbp_drive_t;
endpackage

// >>> tb/dbp_stage.sv
`timescale 1ns/1ns
// Power stage and motor seen from the sequencer's outputs.
module dbp_stage #(
  parameter int SYNC_CYC = 40
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Sequencer side.
  input wire dbp_pkg::dbp_drive_t drive,
  input wire logic [15:0] freq_set,
  output logic [15:0] out_freq,
  output logic track_synced
);
  logic trk_d;
  int cnt;
  // Output frequency ramps toward the set point only while output runs.
  always_ff @(posedge clk) begin
    trk_d <= drive.trk;
    if (rst || !drive.trk) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    if (rst) begin
      out_freq <= 16'h0000;
    end else if (drive.trk && !trk_d) begin
      out_freq <= drive.trk_f;
    end else if (!drive.out_en) begin
      out_freq <= drive.trk ? out_freq : 16'h0000;
    end else if (out_freq + 16'h0010 <= freq_set) begin
      out_freq <= out_freq + 16'h0010;
    end else if (out_freq >= freq_set + 16'h0010) begin
      out_freq <= out_freq - 16'h0010;
    end
  end
  // Rotor lock is reported only after a long search, never at once.
  assign track_synced = drive.trk && cnt >= SYNC_CYC;
endmodule // dbp_stage

// >>> tb/dc_brake_power_loss_restart_tb.sv
`timescale 1ns/1ns
module dc_brake_power_loss_restart_tb;
  localparam int TCK = 10;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [12:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic run_cmd, uv, ovl, track_synced;
  logic [15:0] bus_v, out_freq, enc_speed, freq_set, last_f;
  dbp_pkg::dbp_drive_t drive;
  int err_total, n_compared, k;
  logic [10:0] ri [6] = '{dbp_pkg::IDX_BRK_LVL, dbp_pkg::IDX_INJ_CUR,
    dbp_pkg::IDX_GAIN, dbp_pkg::IDX_MODE, dbp_pkg::IDX_ALLOW_T,
    dbp_pkg::IDX_BLOCK_T};
  logic [15:0] rv [6] = '{16'h0E74, 16'h0000, 16'h0064, 16'h0000,
    16'h0014, 16'h0005};
  dbp_core #(.TICK_CYCLES(TCK), .HIGH_VOLT(1'b0)) dut (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_cmd(run_cmd),
    .undervoltage_indication(uv), .overload_error(ovl), .dc_bus_volt(bus_v),
    .out_freq(out_freq), .enc_speed(enc_speed), .track_synced(track_synced),
    .drive(drive), .irq(irq));
  dbp_stage #(.SYNC_CYC(40)) stage (.clk(clk), .rst(rst), .drive(drive),
    .freq_set(freq_set), .out_freq(out_freq), .track_synced(track_synced));
  // Free-running bench clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [10:0] idx,
    input logic [15:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [10:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rdchk(input logic [10:0] idx, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    check(q, {16'h0000, e});
  endtask
  // Run up to full speed; the start brake runs first when starting from idle.
  task automatic run_up;
    @(posedge clk);
    run_cmd <= 1'b1;
    freq_set <= 16'h0400;
    for (k = 0; k < 400 && out_freq !== 16'h0400; k++) @(negedge clk);
  endtask
  // Ramp stop; thr is the frequency at which output must be dropped.
  task automatic do_stop(input logic [15:0] sel, t, f, thr, input logic brk);
    wr(dbp_pkg::IDX_STOP_SEL, sel);
    wr(dbp_pkg::IDX_STOP_T, t);
    wr(dbp_pkg::IDX_STOP_F, f);
    run_up();
    @(posedge clk);
    run_cmd <= 1'b0;
    freq_set <= 16'h0000;
    for (k = 0; k < 300 && drive.out_en === 1'b1; k++) begin
      last_f = out_freq;
      @(negedge clk);
    end
    check(last_f <= thr && last_f + 16'h0040 > thr, 1);
    check(drive.inj_en, brk);
    for (k = 0; k < 100 && drive.inj_en !== 1'b0; k++) @(negedge clk);
    rdchk(dbp_pkg::IDX_STATUS, 16'h0000);
  endtask
  // Power loss of len cycles; trk tells whether a restart is due.
  task automatic do_loss(input logic [15:0] mode, input int len,
    input logic ol, enc, input logic [15:0] tf, input logic trk);
    wr(dbp_pkg::IDX_MODE, mode);
    wr(dbp_pkg::IDX_CTRL, {15'h0000, enc});
    run_up();
    @(posedge clk);
    uv <= 1'b1;
    ovl <= ol;
    repeat (len) @(negedge clk);
    @(posedge clk);
    uv <= 1'b0;
    ovl <= 1'b0;
    @(negedge clk);
    if (trk) begin
      for (k = 0; k < 200 && drive.trk !== 1'b1; k++) begin
        check(drive.out_en | drive.inj_en, 0);
        @(negedge clk);
      end
      check(k >= 2 * TCK, 1);
      check(drive.trk_f, tf);
      last_f = drive.trk_volt;
      for (k = 0; k < 30 && drive.trk_volt === last_f; k++) @(negedge clk);
      last_f = drive.trk_volt;
      for (k = 0; k < 30 && drive.trk_volt === last_f; k++) @(negedge clk);
      check(drive.trk_volt - last_f, 16'h0032);
      for (k = 0; k < 100 && track_synced !== 1'b1; k++) begin
        check(drive.trk, 1);
        @(negedge clk);
      end
      check(track_synced, 1);
      @(negedge clk);
      check(drive.trk, 0);
      check(drive.out_en, 1);
    end else begin
      repeat (6) @(negedge clk);
      bus(1'b0, dbp_pkg::IDX_STATUS, 16'h0000, rd);
      check(rd[3:0], 4'h8);
      check(drive.out_en, 0);
    end
    @(posedge clk);
    run_cmd <= 1'b0;
    freq_set <= 16'h0000;
    for (k = 0; k < 300 && (drive.out_en | drive.inj_en) !== 0; k++)
      @(negedge clk);
  endtask
  // Watchdog over the whole run.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run();
  end
  // Main sequence.
  initial begin
    {rst, avs_read, avs_write, run_cmd, uv, ovl} = 6'b100000;
    avs_address = 13'h0000;
    avs_writedata = 32'h0000_0000;
    {bus_v, enc_speed, freq_set} = {16'h0000, 16'h0123, 16'h0000};
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdchk(ri[i], rv[i]);
    wr(11'h7FF, 16'hBEEF);
    rdchk(11'h7FF, 16'h0000);
    wr(dbp_pkg::IDX_STATUS, 16'hFFFF);
    rdchk(dbp_pkg::IDX_STATUS, 16'h0000);
    // Chopper threshold, with its interrupt masked, enabled and cleared.
    @(posedge clk) bus_v <= 16'h0E73;
    repeat (5) @(negedge clk);
    check(drive.chop, 0);
    @(posedge clk) bus_v <= 16'h0E74;
    repeat (5) @(negedge clk);
    check(drive.chop, 1);
    check(irq, 0);
    rdchk(dbp_pkg::IDX_IRQ_STAT, 16'h0001);
    wr(dbp_pkg::IDX_IRQ_EN, 16'h0001);
    repeat (2) @(negedge clk);
    check(irq, 1);
    @(posedge clk) bus_v <= 16'h0000;
    wr(dbp_pkg::IDX_IRQ_CLR, 16'h0001);
    repeat (2) @(negedge clk);
    check(irq, 0);
    check(drive.chop, 0);
    rdchk(dbp_pkg::IDX_IRQ_STAT, 16'h0000);
    // Start-up braking at half of rated current.
    wr(dbp_pkg::IDX_RATED, 16'h00C8);
    wr(dbp_pkg::IDX_INJ_CUR, 16'h0032);
    wr(dbp_pkg::IDX_START_T, 16'h0002);
    wr(dbp_pkg::IDX_GAIN, 16'h0032);
    wr(dbp_pkg::IDX_STARTUP_F, 16'h0050);
    wr(dbp_pkg::IDX_MIN_F, 16'h0200);
    wr(dbp_pkg::IDX_ALLOW_T, 16'h0002);
    wr(dbp_pkg::IDX_BLOCK_T, 16'h0003);
    @(posedge clk) run_cmd <= 1'b1;
    for (k = 0; k < 20 && drive.inj_en !== 1'b1; k++) @(negedge clk);
    check(drive.out_en, 0);
    check(drive.inj_amp, 16'h0064);
    for (k = 0; k < 100 && drive.out_en !== 1'b1; k++) @(negedge clk);
    check(drive.inj_en, 0);
    check(k >= TCK && k <= 3 * TCK + 3, 1);
    do_stop(16'h0000, 16'h0001, 16'h0100, 16'h0100, 1'b1);
    do_stop(16'h0001, 16'h0001, 16'h0100, 16'h0100, 1'b0);
    do_stop(16'h0000, 16'h0000, 16'h0100, 16'h0100, 1'b0);
    do_stop(16'h0000, 16'h0001, 16'h0010, 16'h0200, 1'b1);
    do_loss(16'h0001, 5, 1'b0, 1'b0, 16'h0400, 1'b1);
    do_loss(16'h0002, 5, 1'b0, 1'b0, 16'h0200, 1'b1);
    do_loss(16'h0001, 5, 1'b0, 1'b1, 16'h0123, 1'b1);
    do_loss(16'h0000, 5, 1'b0, 1'b0, 16'h0000, 1'b0);
    do_loss(16'h0001, 60, 1'b0, 1'b0, 16'h0000, 1'b0);
    do_loss(16'h0001, 5, 1'b1, 1'b0, 16'h0000, 1'b0);
    // Loss, tracking and trip events stay latched; only the chopper is enabled.
    rdchk(dbp_pkg::IDX_IRQ_STAT, 16'h000E);
    check(irq, 0);
    complete_run();
  end
endmodule // dc_brake_power_loss_restart_tb
